// ### verilog/scratch_bank_defines.vh
// Operation
// R1: exactly 200 sixteen-bit scratch locations of volatile storage, split into typed groups
// R2: host and script both read and write scratch; values return unchanged
// R3: forty float entries decoded from address 46000, read and write
// R4: ten signed entries decoded from address 46080, read and write
// R5: forty unsigned entries decoded from address 46100, read and write
// R6: twenty halfword entries decoded from address 46180, read and write
// R7: access with another data type is completed without any error
// R8: register at 47900 takes byte count, allocating shared memory for fifo
// R9: host sizes fifo at four bytes per 32-bit value, two per halfword
// R10: any allocation up to the free shared memory is accepted
// R11: host leaves enough shared memory for other memory users
// R12: allocation beyond free memory is refused with out of memory error
// R13: writing zero releases the fifo allocation back to the pool
// R14: 32-bit entries take two addresses, high half at lower address
`ifndef SCRATCH_BANK_DEFINES_VH
`define SCRATCH_BANK_DEFINES_VH
`define SCR_BASE 16'hb3b0
`define SCR_FLOAT_BASE 16'hb3b0
`define SCR_SIGNED_BASE 16'hb400
`define SCR_UNSIGNED_BASE 16'hb414
`define SCR_HALF_BASE 16'hb464
`define SCR_HALF_END 16'hb478
`define SCR_WORDS 200
`define FIFO_ALLOC_ADDR 16'hbb1c
`define FIFO_ALLOC_ADDR_LO 16'hbb1d
`define SHARED_MEM_BYTES 32'h00010000
`define FIFO_RESET 32'h00000000
`endif

// ### verilog/scratch_ram.v
`timescale 1ns/10ps
`default_nettype none
// dual port scratch storage, host port a and script port b
module scratch_ram #(
  parameter WORDS = 200,
  parameter AW = 8
) (
  input wire clk,
  input wire ce,
  input wire a_we,
  input wire [AW-1:0] a_addr,
  input wire [15:0] a_wdata,
  output reg [15:0] a_rdata,
  input wire b_we,
  input wire [AW-1:0] b_addr,
  input wire [15:0] b_wdata,
  output reg [15:0] b_rdata
);
  reg [15:0] mem [0:WORDS-1];

  always @(posedge clk) begin
    if (ce) begin
      if (a_we) begin
        mem[a_addr] <= a_wdata; // [R2]
      end
      // script write yields to a host write at the same word
      if (b_we && !(a_we && a_addr == b_addr)) begin
        mem[b_addr] <= b_wdata; // [R2]
      end
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule // scratch_ram
`default_nettype wire

// ### verilog/fifo_allocator.v
`timescale 1ns/10ps
`default_nettype none
`include "scratch_bank_defines.vh"
// tracks shared memory held by the user fifo
module fifo_allocator (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire req,
  input wire [31:0] bytes,
  input wire [31:0] other_used,
  output reg [31:0] alloc_q,
  output reg done_q,
  output reg err_q
);
  wire [32:0] free_w;
  assign free_w = {1'b0, `SHARED_MEM_BYTES} - {1'b0, other_used};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_q <= `FIFO_RESET;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce) begin
      done_q <= req;
      if (req) begin
        if (bytes == 32'h00000000) begin
          alloc_q <= 32'h00000000; // [R13]
          err_q <= 1'b0;
        end else if (free_w[32] || {1'b0, bytes} > free_w) begin
          err_q <= 1'b1; // [R12]
        end else begin
          alloc_q <= bytes; // [R8] [R10]
          err_q <= 1'b0;
        end
      end
    end
  end
endmodule // fifo_allocator
`default_nettype wire

// ### verilog/shared_scratch_ram_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "scratch_bank_defines.vh"
module shared_scratch_ram_bank (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_N,
  input wire CE,
  // host register port, 16-bit modbus words
  input wire HOST_REQ,
  input wire HOST_WR,
  input wire [15:0] HOST_ADDR,
  input wire [15:0] HOST_WDATA,
  output reg HOST_ACK,
  output reg HOST_ERR,
  output reg [15:0] HOST_RDATA,
  // script port, same addressing
  input wire SCRIPT_REQ,
  input wire SCRIPT_WR,
  input wire [15:0] SCRIPT_ADDR,
  input wire [15:0] SCRIPT_WDATA,
  output reg SCRIPT_ACK,
  output reg SCRIPT_ERR,
  output reg [15:0] SCRIPT_RDATA,
  // shared memory held by other users, in bytes
  input wire [31:0] OTHER_MEM_USED,
  // allocation state
  output reg [31:0] FIFO_ALLOC_BYTES,
  output reg OUT_OF_MEMORY_ERROR
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // true when lo <= a < hi
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a < hi);
    end
  endfunction

  function in_float;
    input [15:0] a;
    begin
      in_float = in_range(a, `SCR_FLOAT_BASE, `SCR_SIGNED_BASE); // [R3]
    end
  endfunction

  function in_signed;
    input [15:0] a;
    begin
      in_signed = in_range(a, `SCR_SIGNED_BASE, `SCR_UNSIGNED_BASE); // [R4]
    end
  endfunction

  function in_unsigned;
    input [15:0] a;
    begin
      in_unsigned = in_range(a, `SCR_UNSIGNED_BASE, `SCR_HALF_BASE); // [R5]
    end
  endfunction

  function in_half;
    input [15:0] a;
    begin
      in_half = in_range(a, `SCR_HALF_BASE, `SCR_HALF_END); // [R6]
    end
  endfunction

  // the four groups abut, so together they cover all scratch words
  function in_scratch;
    input [15:0] a;
    begin
      in_scratch = in_float(a) || in_signed(a) || in_unsigned(a) || in_half(a); // [R1]
    end
  endfunction

  // word number inside the bank; each 32-bit entry is two words
  function [7:0] scr_index;
    input [15:0] a;
    reg [15:0] d;
    begin
      d = a - `SCR_BASE;
      scr_index = d[7:0]; // [R14]
    end
  endfunction

  function is_fifo_hi;
    input [15:0] a;
    begin
      is_fifo_hi = (a == `FIFO_ALLOC_ADDR);
    end
  endfunction

  function is_fifo_lo;
    input [15:0] a;
    begin
      is_fifo_lo = (a == `FIFO_ALLOC_ADDR_LO);
    end
  endfunction

  function is_fifo;
    input [15:0] a;
    begin
      is_fifo = is_fifo_hi(a) || is_fifo_lo(a);
    end
  endfunction

  wire h_scr = in_scratch(HOST_ADDR);
  wire s_scr = in_scratch(SCRIPT_ADDR);
  wire [7:0] h_idx = scr_index(HOST_ADDR);
  wire [7:0] s_idx = scr_index(SCRIPT_ADDR);
  wire [15:0] h_rd;
  wire [15:0] s_rd;

  // ------------------------------------------------------------
  // host request decode
  // ------------------------------------------------------------
  // a type other than the group's own is never refused
  reg h_scr_we;
  reg h_hi_we;
  reg h_lo_we;

  always @* begin
    h_scr_we = 1'b0;
    h_hi_we = 1'b0;
    h_lo_we = 1'b0;
    if (HOST_REQ && HOST_WR) begin
      if (h_scr) begin
        h_scr_we = 1'b1; // [R7]
      end else if (is_fifo_hi(HOST_ADDR)) begin
        h_hi_we = 1'b1; // [R14]
      end else if (is_fifo_lo(HOST_ADDR)) begin
        h_lo_we = 1'b1; // [R8]
      end
    end
  end

  // ------------------------------------------------------------
  // script request decode
  // ------------------------------------------------------------
  // the script reaches scratch words only, never the fifo register
  reg s_scr_we;

  always @* begin
    s_scr_we = 1'b0;
    if (SCRIPT_REQ && SCRIPT_WR && s_scr) begin
      s_scr_we = 1'b1; // [R2]
    end
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  scratch_ram #(.WORDS(`SCR_WORDS), .AW(8)) u_ram (
    .clk(CORE_CLK),
    .ce(CE),
    .a_we(h_scr_we), // [R7]
    .a_addr(h_idx),
    .a_wdata(HOST_WDATA),
    .a_rdata(h_rd),
    .b_we(s_scr_we),
    .b_addr(s_idx),
    .b_wdata(SCRIPT_WDATA),
    .b_rdata(s_rd)
  );

  // ------------------------------------------------------------
  // fifo allocation, high half written first then low half commits
  // ------------------------------------------------------------
  reg [15:0] hi_q;
  wire h_fifo = HOST_REQ && is_fifo(HOST_ADDR);
  wire h_fifo_lo = is_fifo_lo(HOST_ADDR);
  // only the low half write asks the allocator, with the staged high half
  wire alloc_req = h_lo_we;
  wire [31:0] alloc_q;
  wire alloc_done;
  wire alloc_err;

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_q <= 16'h0000;
    end else if (CE && h_hi_we) begin
      hi_q <= HOST_WDATA; // [R14]
    end
  end

  fifo_allocator u_alloc (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .req(alloc_req),
    .bytes({hi_q, HOST_WDATA}),
    .other_used(OTHER_MEM_USED),
    .alloc_q(alloc_q),
    .done_q(alloc_done),
    .err_q(alloc_err)
  );

  // ------------------------------------------------------------
  // answer helpers
  // ------------------------------------------------------------
  // read data travels only on reads; writes and refusals answer zero
  function [15:0] read_word;
    input pend;
    input wr;
    input hit;
    input [15:0] word;
    begin
      read_word = (pend && !wr && hit) ? word : 16'h0000;
    end
  endfunction

  reg h_pend_q;
  reg h_wr_q;
  reg h_scr_q;
  reg h_fifo_q;
  reg h_lo_q;
  reg s_pend_q;
  reg s_wr_q;
  reg s_scr_q;
  wire [15:0] fifo_half = h_lo_q ? alloc_q[15:0] : alloc_q[31:16];

  // ------------------------------------------------------------
  // host request stage, one cycle after the request is taken
  // ------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      h_pend_q <= 1'b0;
      h_wr_q <= 1'b0;
      h_scr_q <= 1'b0;
      h_fifo_q <= 1'b0;
      h_lo_q <= 1'b0;
    end else if (CE) begin
      // an allocation commit answers through the allocator instead
      h_pend_q <= HOST_REQ && !alloc_req;
      h_wr_q <= HOST_WR;
      h_scr_q <= h_scr;
      h_fifo_q <= h_fifo;
      h_lo_q <= h_fifo_lo;
    end
  end

  // ------------------------------------------------------------
  // script request stage
  // ------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_pend_q <= 1'b0;
      s_wr_q <= 1'b0;
      s_scr_q <= 1'b0;
    end else if (CE) begin
      s_pend_q <= SCRIPT_REQ;
      s_wr_q <= SCRIPT_WR;
      s_scr_q <= s_scr;
    end
  end

  // ------------------------------------------------------------
  // host answer, two cycles after the request is taken
  // ------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HOST_ACK <= 1'b0;
      HOST_ERR <= 1'b0;
      HOST_RDATA <= 16'h0000;
    end else if (CE) begin
      HOST_ACK <= h_pend_q || alloc_done;
      HOST_ERR <= (h_pend_q && !h_scr_q && !h_fifo_q) || (alloc_done && alloc_err); // [R12]
      if (h_scr_q) begin
        HOST_RDATA <= read_word(h_pend_q, h_wr_q, 1'b1, h_rd); // [R2]
      end else begin
        HOST_RDATA <= read_word(h_pend_q, h_wr_q, h_fifo_q, fifo_half); // [R14]
      end
    end
  end

  // ------------------------------------------------------------
  // script answer, same timing as the host
  // ------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCRIPT_ACK <= 1'b0;
      SCRIPT_ERR <= 1'b0;
      SCRIPT_RDATA <= 16'h0000;
    end else if (CE) begin
      SCRIPT_ACK <= s_pend_q;
      SCRIPT_ERR <= s_pend_q && !s_scr_q;
      SCRIPT_RDATA <= read_word(s_pend_q, s_wr_q, s_scr_q, s_rd); // [R2]
    end
  end

  // ------------------------------------------------------------
  // allocation state, shown with the commit's answer
  // ------------------------------------------------------------
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIFO_ALLOC_BYTES <= `FIFO_RESET;
      OUT_OF_MEMORY_ERROR <= 1'b0;
    end else if (CE) begin
      FIFO_ALLOC_BYTES <= alloc_q; // [R8]
      OUT_OF_MEMORY_ERROR <= alloc_err; // [R12]
    end
  end
endmodule // shared_scratch_ram_bank
`default_nettype wire

// ### dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// requester standing in for host or script
// ----------------------------------------
module host_model (
  // clock
  input wire logic clk,
  // request
  output logic req,
  output logic wr,
  output logic [15:0] addr,
  output logic [15:0] wdata,
  // answer
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] rdata
);
  initial begin
    req = 1'b0;
    wr = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
  end
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic e, output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    // released address and data lines show the inverse, never the stale value
    addr = ~a;
    wdata = ~d;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      #1;
      if (ack === 1'b1) begin
        ok = 1'b1;
        e = err;
        q = rdata;
      end
    end
  endtask
endmodule // host_model
`default_nettype wire

// ### dv/shared_scratch_ram_bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// bank port checks
// ----------------
module shared_scratch_ram_bank_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // host and script ports
  input wire logic HOST_REQ,
  input wire logic [15:0] HOST_ADDR,
  input wire logic HOST_ACK,
  input wire logic HOST_ERR,
  input wire logic [15:0] HOST_RDATA,
  input wire logic SCRIPT_REQ,
  input wire logic [15:0] SCRIPT_ADDR,
  input wire logic SCRIPT_ACK,
  input wire logic SCRIPT_ERR,
  // allocation
  input wire logic [31:0] FIFO_ALLOC_BYTES,
  input wire logic OUT_OF_MEMORY_ERROR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire scr = HOST_ADDR >= 16'hb3b0 && HOST_ADDR <= 16'hb477;
  wire fifo = HOST_ADDR == 16'hbb1c || HOST_ADDR == 16'hbb1d;
  a_host_ack: assert property (HOST_REQ && CE |-> ##2 HOST_ACK)
    else $error("host ack missing");
  a_script_ack: assert property (SCRIPT_REQ && CE |-> ##2 SCRIPT_ACK)
    else $error("script ack missing");
  a_ack_cause: assert property (HOST_ACK |-> $past(HOST_REQ, 2))
    else $error("host ack without request");
  a_scratch_no_err: assert property (HOST_REQ && scr |-> ##2 !HOST_ERR)
    else $error("scratch access refused");
  a_unmapped_err: assert property (HOST_REQ && CE && !scr && !fifo |-> ##2 HOST_ERR)
    else $error("unmapped access accepted");
  a_err_rdata: assert property (HOST_ERR |-> HOST_RDATA == 16'h0000)
    else $error("read data on error");
  a_alloc_commit: assert property ($changed(FIFO_ALLOC_BYTES) |-> HOST_ACK && !HOST_ERR)
    else $error("allocation changed without commit");
  a_oom_flag: assert property (HOST_ACK && HOST_ERR && $past(HOST_ADDR, 2) == 16'hbb1d
                               |-> OUT_OF_MEMORY_ERROR)
    else $error("refusal without flag");
  a_script_fifo: assert property (SCRIPT_REQ && CE && SCRIPT_ADDR == 16'hbb1c |-> ##2 SCRIPT_ERR)
    else $error("script reached fifo");
  c_write: cover property (HOST_ACK && !HOST_ERR);
  c_oom: cover property (OUT_OF_MEMORY_ERROR);
  c_script: cover property (SCRIPT_ACK);
endmodule // shared_scratch_ram_bank_chk
bind shared_scratch_ram_bank shared_scratch_ram_bank_chk chk_inst (.CORE_CLK, .RST_N, .CE,
  .HOST_REQ, .HOST_ADDR, .HOST_ACK, .HOST_ERR, .HOST_RDATA, .SCRIPT_REQ, .SCRIPT_ADDR,
  .SCRIPT_ACK, .SCRIPT_ERR, .FIFO_ALLOC_BYTES, .OUT_OF_MEMORY_ERROR);
`default_nettype wire

// ### dv/shared_scratch_ram_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module shared_scratch_ram_bank_tb;
  logic clk, rst_n, ce, hreq, hwr, sreq, swr, hack, herr, sack, serr, oom, e, ok, e2, ok2;
  logic [15:0] haddr, hwd, hrd, saddr, swd, srd, q, q2;
  logic [31:0] other, alloc;
  logic [15:0] ref_mem [0:199];
  int err_count, checked, seed, i;
  shared_scratch_ram_bank shared_scratch_ram_bank_inst (.CORE_CLK(clk), .RST_N(rst_n),
    .CE(ce), .HOST_REQ(hreq), .HOST_WR(hwr), .HOST_ADDR(haddr), .HOST_WDATA(hwd),
    .HOST_ACK(hack), .HOST_ERR(herr), .HOST_RDATA(hrd), .SCRIPT_REQ(sreq), .SCRIPT_WR(swr),
    .SCRIPT_ADDR(saddr), .SCRIPT_WDATA(swd), .SCRIPT_ACK(sack), .SCRIPT_ERR(serr),
    .SCRIPT_RDATA(srd), .OTHER_MEM_USED(other), .FIFO_ALLOC_BYTES(alloc),
    .OUT_OF_MEMORY_ERROR(oom));
  host_model host_inst (.clk(clk), .req(hreq), .wr(hwr), .addr(haddr), .wdata(hwd),
    .ack(hack), .err(herr), .rdata(hrd));
  host_model script_inst (.clk(clk), .req(sreq), .wr(swr), .addr(saddr), .wdata(swd),
    .ack(sack), .err(serr), .rdata(srd));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one access on host (s=0) or script (s=1) port with expected answer
  task automatic acc(input logic s, input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic xe, input logic [15:0] xq);
    if (s) script_inst.access(w, a, d, e, q, ok);
    else host_inst.access(w, a, d, e, q, ok);
    chk("ack", 1, ok);
    if (!ok) stop_test();
    chk("err", xe, e);
    chk("rdata", xq, q);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    other = 32'h0;
    ce = 1'b1;
    err_count = 0;
    checked = 0;
    seed = 85174;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 200; i++) begin
      ref_mem[i] = 16'($random(seed));
      acc(0, 1, 16'hb3b0 + i[15:0], ref_mem[i], 0, 0);
    end
    for (i = 0; i < 200; i++) begin
      acc(1, 0, 16'hb3b0 + i[15:0], 0, 0, ref_mem[i]);
      ref_mem[i] = 16'($random(seed));
      acc(1, 1, 16'hb3b0 + i[15:0], ref_mem[i], 0, 0);
    end
    for (i = 0; i < 200; i++) acc(0, 0, 16'hb3b0 + i[15:0], 0, 0, ref_mem[i]);
    $display("test scratch done");
    @(posedge clk);
    #1 ce = 1'b0;
    host_inst.access(1, 16'hb3b0, ~ref_mem[0], e, q, ok);
    chk("frozen ack", 0, ok);
    ce = 1'b1;
    acc(0, 0, 16'hb3b0, 0, 0, ref_mem[0]);
    fork
      host_inst.access(1, 16'hb464, 16'h1111, e, q, ok);
      script_inst.access(1, 16'hb464, 16'h2222, e2, q2, ok2);
    join
    chk("clash host ack", 1, ok);
    chk("clash script ack", 1, ok2);
    chk("clash script err", 0, e2);
    acc(1, 0, 16'hb464, 0, 0, 16'h1111);
    $display("test freeze and clash done");
    acc(0, 0, 16'hb3af, 0, 1, 0);
    acc(0, 1, 16'hb478, 16'h5a5a, 1, 0);
    acc(1, 1, 16'hbb1c, 0, 1, 0);
    $display("test unmapped done");
    acc(0, 1, 16'hbb1c, 0, 0, 0);
    acc(0, 1, 16'hbb1d, 16'h0064, 0, 0);
    chk("alloc", 32'h64, alloc);
    acc(0, 0, 16'hbb1d, 0, 0, 16'h0064);
    other = 32'h8000;
    acc(0, 1, 16'hbb1d, 16'h8001, 1, 0);
    chk("oom", 1, oom);
    chk("alloc", 32'h64, alloc);
    acc(0, 1, 16'hbb1d, 16'h8000, 0, 0);
    chk("oom", 0, oom);
    chk("alloc", 32'h8000, alloc);
    acc(0, 1, 16'hbb1d, 0, 0, 0);
    chk("alloc", 0, alloc);
    $display("test fifo done");
    stop_test();
  end
endmodule // shared_scratch_ram_bank_tb
`default_nettype wire
